//--- rtl/pgwl_pkg.sv
// pgwl_pkg: shared constants and types of the power-good and write-lock register bank.
// assumes a 200 MHz core clock and a serial two-wire host on the far side.
package pgwl_pkg;

    // register offsets
    localparam logic [7:0] PGWL_OFS_KEY    = 8'h0b;
    localparam logic [7:0] PGWL_OFS_STATUS = 8'h0c;
    localparam logic [7:0] PGWL_OFS_CFG    = 8'h0d;
    localparam logic [7:0] PGWL_OFS_BUCK1  = 8'h0e;

    // reset values
    localparam logic [7:0] PGWL_RST_KEY    = 8'h00;
    localparam logic [7:0] PGWL_RST_STATUS = 8'h00;
    localparam logic [7:0] PGWL_RST_CFG    = 8'h0c;
    localparam logic [7:0] PGWL_RST_BUCK1  = 8'h18;

    // the single code that opens one protected write
    localparam logic [7:0] PGWL_UNLOCK_KEY = 8'h7d;

    // config field positions and writable bits
    localparam int         PGWL_CFG_LIN_A_MASK = 3;
    localparam int         PGWL_CFG_LIN_B_MASK = 2;
    localparam int         PGWL_CFG_DLY_LSB    = 0;
    localparam logic [7:0] PGWL_CFG_WMASK      = 8'h0f;

    // status field positions
    localparam int PGWL_ST_LIN_C  = 6;
    localparam int PGWL_ST_LIN_D  = 5;
    localparam int PGWL_ST_BUCK_A = 4;
    localparam int PGWL_ST_BUCK_B = 3;
    localparam int PGWL_ST_BUCK_C = 2;
    localparam int PGWL_ST_LIN_A  = 1;
    localparam int PGWL_ST_LIN_B  = 0;

    // default bus address, arbitrary value
    localparam logic [6:0] PGWL_BUS_ADDR = 7'h2a;

    // delay timing
    localparam int PGWL_CLK_KHZ = 200000;
    localparam int PGWL_DLY0_MS = 20;
    localparam int PGWL_DLY1_MS = 100;
    localparam int PGWL_DLY2_MS = 200;
    localparam int PGWL_DLY3_MS = 400;
    localparam int PGWL_DLY_W   = 27;
    localparam logic [PGWL_DLY_W-1:0] PGWL_DLY0_CYC = PGWL_DLY_W'(PGWL_DLY0_MS * PGWL_CLK_KHZ);
    localparam logic [PGWL_DLY_W-1:0] PGWL_DLY1_CYC = PGWL_DLY_W'(PGWL_DLY1_MS * PGWL_CLK_KHZ);
    localparam logic [PGWL_DLY_W-1:0] PGWL_DLY2_CYC = PGWL_DLY_W'(PGWL_DLY2_MS * PGWL_CLK_KHZ);
    localparam logic [PGWL_DLY_W-1:0] PGWL_DLY3_CYC = PGWL_DLY_W'(PGWL_DLY3_MS * PGWL_CLK_KHZ);

    // rail good inputs, packed in status bit order 6..0
    typedef struct packed {
        logic linearCGood;
        logic linearDGood;
        logic buckAGood;
        logic buckBGood;
        logic buckCGood;
        logic linearAGood;
        logic linearBGood;
    } pgwl_rails_s;

    // serial slave states, one-hot
    typedef enum logic [9:0] {
        PGWL_IDLE     = 10'h001,
        PGWL_ADDR     = 10'h002,
        PGWL_ADDR_ACK = 10'h004,
        PGWL_PTR      = 10'h008,
        PGWL_PTR_ACK  = 10'h010,
        PGWL_WDATA    = 10'h020,
        PGWL_WACK     = 10'h040,
        PGWL_RDATA    = 10'h080,
        PGWL_RACK     = 10'h100,
        PGWL_IGNORE   = 10'h200
    } pgwl_state_e;

endpackage

//--- rtl/pgwl_rails_ok_timer.sv
// pgwl_rails_ok_timer: qualifies the combined rail good level with a selectable delay.
// assumes allGood is already synchronous to core_clk.
`timescale 1ns/1ps
module pgwl_rails_ok_timer
    import pgwl_pkg::*;
#(
    parameter logic [PGWL_DLY_W-1:0] DLY0_CYC = PGWL_DLY0_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY1_CYC = PGWL_DLY1_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY2_CYC = PGWL_DLY2_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY3_CYC = PGWL_DLY3_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       allGood,
    input  wire logic [1:0] delaySel,
    output logic            railsOk
);

    typedef struct packed {
        logic [PGWL_DLY_W-1:0] cnt;
        logic                  ok;
    } pgwl_tmr_s;

    pgwl_tmr_s stateFf;
    pgwl_tmr_s nxtState;

    // delay selection in ascending order
    function automatic logic [PGWL_DLY_W-1:0] delayCycles(input logic [1:0] sel);
        case (sel)
            2'h0:    delayCycles = DLY0_CYC;
            2'h1:    delayCycles = DLY1_CYC;
            2'h2:    delayCycles = DLY2_CYC;
            default: delayCycles = DLY3_CYC;
        endcase
    endfunction

    // rise after delay, fall at once
    always_comb begin
        nxtState = stateFf;
        if (!allGood) begin
            nxtState.cnt = '0;
            nxtState.ok  = 1'b0;
        end else if (!stateFf.ok) begin
            if (stateFf.cnt >= delayCycles(delaySel) - PGWL_DLY_W'(1)) begin
                nxtState.ok = 1'b1;
            end else begin
                nxtState.cnt = stateFf.cnt + PGWL_DLY_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign railsOk = stateFf.ok; // straight from a flip-flop

endmodule

//--- rtl/pgwl_power_good_lock.sv
// pgwl_power_good_lock: two-wire register slave with the write-unlock key,
// rail good status, rail good config and the protected buck one control register.
// assumes scl/sda and rail flags arrive asynchronously; the pad resolves sda from sdaOe.
`timescale 1ns/1ps

// Function
// - key then next write opens one register
// - key clears after the following transaction
// - any other key value keeps lock
// - status bits 4..2 show buck regulation
// - status bits 1..0 show linear a, b
// - bits 6..5 linear c, d or switch
// - config bit 3 masks linear a
// - config bit 2 masks linear b
// - config bits 1..0 pick output delay
// - config and buck one need unlock
// - reserved bits read zero, ignore writes
module pgwl_power_good_lock
    import pgwl_pkg::*;
#(
    parameter logic [6:0]            BUS_ADDR = PGWL_BUS_ADDR,
    parameter logic [PGWL_DLY_W-1:0] DLY0_CYC = PGWL_DLY0_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY1_CYC = PGWL_DLY1_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY2_CYC = PGWL_DLY2_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY3_CYC = PGWL_DLY3_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire pgwl_rails_s railGood,
    input  wire logic        loadSwitchA,
    input  wire logic        loadSwitchB,
    output logic             railsOkOutput,
    output logic [7:0]       buckOneControl
);

    // whole module state
    typedef struct packed {
        pgwl_state_e st;
        logic        sclSync1;
        logic        sclSync2;
        logic        sclDly;
        logic        sdaSync1;
        logic        sdaSync2;
        logic        sdaDly;
        logic [6:0]  railSync1;
        logic [6:0]  railSync2;
        logic [1:0]  lsSync1;
        logic [1:0]  lsSync2;
        logic [2:0]  bitCnt;
        logic [7:0]  shift;
        logic        byteDone;
        logic        readMode;
        logic        inTxn;
        logic [7:0]  ptr;
        logic        sdaDrive;
        logic        sdaLevel;
        logic [7:0]  unlockKeyField;
        logic        keyFresh;
        logic        keyPending;
        logic [7:0]  status;
        logic [7:0]  goodCfg;
        logic [7:0]  buckOne;
        logic        allGood;
    } pgwl_main_s;

    pgwl_main_s stateFf;
    pgwl_main_s nxtState;

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic unlocked;
    logic [7:0] rdByte;

    // register read decode
    function automatic logic [7:0] readReg(input pgwl_main_s s, input logic [7:0] ofs);
        case (ofs)
            PGWL_OFS_KEY:    readReg = s.unlockKeyField;
            PGWL_OFS_STATUS: readReg = s.status;
            PGWL_OFS_CFG:    readReg = s.goodCfg;
            PGWL_OFS_BUCK1:  readReg = s.buckOne;
            default:         readReg = 8'h00;
        endcase
    endfunction

    // protected register decode
    function automatic logic isProtected(input logic [7:0] ofs);
        isProtected = (ofs == PGWL_OFS_CFG) || (ofs == PGWL_OFS_BUCK1);
    endfunction

    // bus events seen on the second synchroniser stage
    assign sclRise   = stateFf.sclSync2 & ~stateFf.sclDly;
    assign sclFall   = ~stateFf.sclSync2 & stateFf.sclDly;
    assign startSeen = stateFf.sclSync2 & stateFf.sclDly & stateFf.sdaDly & ~stateFf.sdaSync2;
    assign stopSeen  = stateFf.sclSync2 & stateFf.sclDly & ~stateFf.sdaDly & stateFf.sdaSync2;

    // only the exact code, written in an earlier transaction, opens
    // every other key value stays locked
    assign unlocked = (stateFf.unlockKeyField == PGWL_UNLOCK_KEY) & stateFf.keyPending;

    // byte at the pointer, loaded into the shifter for a read
    assign rdByte = readReg(stateFf, stateFf.ptr);

    always_comb begin
        nxtState = stateFf;

        // pin synchronisers and edge history
        nxtState.sclSync1  = sclIn;
        nxtState.sclSync2  = stateFf.sclSync1;
        nxtState.sclDly    = stateFf.sclSync2;
        nxtState.sdaSync1  = sdaIn;
        nxtState.sdaSync2  = stateFf.sdaSync1;
        nxtState.sdaDly    = stateFf.sdaSync2;
        nxtState.railSync1 = railGood;
        nxtState.railSync2 = stateFf.railSync1;
        nxtState.lsSync1   = {loadSwitchA, loadSwitchB};
        nxtState.lsSync2   = stateFf.lsSync1;
        nxtState.sdaLevel  = 1'b0; // open drain, only the enable moves

        nxtState.status[PGWL_ST_BUCK_A] = stateFf.railSync2[PGWL_ST_BUCK_A];
        nxtState.status[PGWL_ST_BUCK_B] = stateFf.railSync2[PGWL_ST_BUCK_B];
        nxtState.status[PGWL_ST_BUCK_C] = stateFf.railSync2[PGWL_ST_BUCK_C];
        nxtState.status[PGWL_ST_LIN_A] = stateFf.railSync2[PGWL_ST_LIN_A];
        nxtState.status[PGWL_ST_LIN_B] = stateFf.railSync2[PGWL_ST_LIN_B];
        // linear c and d, good or switch
        nxtState.status[PGWL_ST_LIN_C] = stateFf.railSync2[PGWL_ST_LIN_C] | stateFf.lsSync2[1];
        nxtState.status[PGWL_ST_LIN_D] = stateFf.railSync2[PGWL_ST_LIN_D] | stateFf.lsSync2[0];
        nxtState.status[7] = 1'b0;

        nxtState.allGood = (&stateFf.status[6:2])
            & (stateFf.status[PGWL_ST_LIN_A] | stateFf.goodCfg[PGWL_CFG_LIN_A_MASK])
            & (stateFf.status[PGWL_ST_LIN_B] | stateFf.goodCfg[PGWL_CFG_LIN_B_MASK]);

        if (startSeen || stopSeen) begin
            // key ages out at the end of each transaction
            if (stateFf.inTxn) begin
                nxtState.keyPending = stateFf.keyFresh;
                nxtState.keyFresh   = 1'b0;
                if (stateFf.keyPending && !stateFf.keyFresh) begin
                    nxtState.unlockKeyField = PGWL_RST_KEY;
                end
            end
            nxtState.sdaDrive = 1'b0;
            nxtState.bitCnt   = 3'h0;
            nxtState.byteDone = 1'b0;
            nxtState.inTxn    = startSeen;
            nxtState.st       = startSeen ? PGWL_ADDR : PGWL_IDLE;
        end else begin
            case (stateFf.st)
                PGWL_IDLE, PGWL_IGNORE: begin
                    nxtState.sdaDrive = 1'b0;
                end
                PGWL_ADDR, PGWL_PTR, PGWL_WDATA: begin
                    // shift in one bit per rising clock
                    if (sclRise) begin
                        nxtState.shift  = {stateFf.shift[6:0], stateFf.sdaSync2};
                        nxtState.bitCnt = stateFf.bitCnt + 3'h1;
                        if (stateFf.bitCnt == 3'h7) begin
                            nxtState.byteDone = 1'b1;
                        end
                    end else if (sclFall && stateFf.byteDone) begin
                        nxtState.byteDone = 1'b0;
                        nxtState.bitCnt   = 3'h0;
                        nxtState.sdaDrive = 1'b1;
                        if (stateFf.st == PGWL_ADDR) begin
                            if (stateFf.shift[7:1] == BUS_ADDR) begin
                                nxtState.readMode = stateFf.shift[0];
                                nxtState.st       = PGWL_ADDR_ACK;
                            end else begin
                                nxtState.sdaDrive = 1'b0;
                                nxtState.st       = PGWL_IGNORE;
                            end
                        end else if (stateFf.st == PGWL_PTR) begin
                            nxtState.ptr = stateFf.shift;
                            nxtState.st  = PGWL_PTR_ACK;
                        end else begin
                            nxtState.ptr = stateFf.ptr + 8'h01;
                            nxtState.st  = PGWL_WACK;
                            if (stateFf.ptr == PGWL_OFS_KEY) begin
                                // key value stored, becomes live after this transaction
                                nxtState.unlockKeyField = stateFf.shift;
                                nxtState.keyFresh       = 1'b1;
                            end else if (isProtected(stateFf.ptr)) begin
                                if (unlocked) begin
                                    if (stateFf.ptr == PGWL_OFS_CFG) begin
                                        nxtState.goodCfg = stateFf.shift & PGWL_CFG_WMASK;
                                    end else begin
                                        nxtState.buckOne = stateFf.shift;
                                    end
                                    nxtState.unlockKeyField = PGWL_RST_KEY;
                                    nxtState.keyPending     = 1'b0;
                                end
                            end
                        end
                    end
                end
                PGWL_ADDR_ACK, PGWL_PTR_ACK, PGWL_WACK: begin
                    // release sda after the acknowledge clock; after a read address acknowledge, drive the first data bit instead
                    if (sclFall) begin
                        nxtState.sdaDrive = 1'b0;
                        if (stateFf.st == PGWL_ADDR_ACK && stateFf.readMode) begin
                            nxtState.shift    = rdByte;
                            nxtState.sdaDrive = ~rdByte[7];
                            nxtState.ptr      = stateFf.ptr + 8'h01;
                            nxtState.bitCnt   = 3'h0;
                            nxtState.st       = PGWL_RDATA;
                        end else if (stateFf.st == PGWL_ADDR_ACK) begin
                            nxtState.st = PGWL_PTR;
                        end else begin
                            nxtState.st = PGWL_WDATA;
                        end
                    end
                end
                PGWL_RDATA: begin
                    // present the next bit after each falling clock
                    if (sclFall) begin
                        if (stateFf.bitCnt == 3'h7) begin
                            nxtState.sdaDrive = 1'b0;
                            nxtState.byteDone = 1'b0;
                            nxtState.st       = PGWL_RACK;
                        end else begin
                            nxtState.shift    = {stateFf.shift[6:0], 1'b0};
                            nxtState.sdaDrive = ~stateFf.shift[6];
                            nxtState.bitCnt   = stateFf.bitCnt + 3'h1;
                        end
                    end
                end
                PGWL_RACK: begin
                    // host acknowledge decides whether another byte follows
                    if (sclRise) begin
                        if (stateFf.sdaSync2) begin
                            nxtState.st = PGWL_IGNORE;
                        end else begin
                            nxtState.byteDone = 1'b1;
                        end
                    end else if (sclFall && stateFf.byteDone) begin
                        nxtState.byteDone = 1'b0;
                        nxtState.shift    = rdByte;
                        nxtState.sdaDrive = ~rdByte[7];
                        nxtState.ptr      = stateFf.ptr + 8'h01;
                        nxtState.bitCnt   = 3'h0;
                        nxtState.st       = PGWL_RDATA;
                    end
                end
                default: begin
                    nxtState.sdaDrive = 1'b0;
                    nxtState.st       = PGWL_IDLE;
                end
            endcase
        end
    end

    // state register, constants only under reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateFf                <= '0;
            stateFf.st             <= PGWL_IDLE;
            stateFf.sclSync1       <= 1'b1;
            stateFf.sclSync2       <= 1'b1;
            stateFf.sclDly         <= 1'b1;
            stateFf.sdaSync1       <= 1'b1;
            stateFf.sdaSync2       <= 1'b1;
            stateFf.sdaDly         <= 1'b1;
            stateFf.unlockKeyField <= PGWL_RST_KEY;
            stateFf.status         <= PGWL_RST_STATUS;
            stateFf.goodCfg        <= PGWL_RST_CFG;
            stateFf.buckOne        <= PGWL_RST_BUCK1;
        end else begin
            stateFf <= nxtState;
        end
    end

    pgwl_rails_ok_timer #(
        .DLY0_CYC (DLY0_CYC),
        .DLY1_CYC (DLY1_CYC),
        .DLY2_CYC (DLY2_CYC),
        .DLY3_CYC (DLY3_CYC)
    ) uRailsOkTimer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .allGood  (stateFf.allGood),
        .delaySel (stateFf.goodCfg[PGWL_CFG_DLY_LSB +: 2]),
        .railsOk  (railsOkOutput)
    );

    // outputs straight from flip-flops
    assign sdaOut         = stateFf.sdaLevel;
    assign sdaOe          = stateFf.sdaDrive;
    assign buckOneControl = stateFf.buckOne;

endmodule

//--- sim/pgwl_checker.sv
// pgwl_checker: port-level assertions for the power-good and write-lock bank.
// assumes only the top module's ports are visible; bound at the foot of this file.
`timescale 1ns/1ps
module pgwl_checker
    import pgwl_pkg::*;
#(
    parameter logic [6:0]            BUS_ADDR = PGWL_BUS_ADDR,
    parameter logic [PGWL_DLY_W-1:0] DLY0_CYC = PGWL_DLY0_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY1_CYC = PGWL_DLY1_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY2_CYC = PGWL_DLY2_CYC,
    parameter logic [PGWL_DLY_W-1:0] DLY3_CYC = PGWL_DLY3_CYC
) (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire pgwl_rails_s railGood,
    input wire logic        loadSwitchA,
    input wire logic        loadSwitchB,
    input wire logic        railsOkOutput,
    input wire logic [7:0]  buckOneControl
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // buck one control, output and sda enable leave reset at their documented values
    a_reset_values: assert property ($rose(rst_b) |-> buckOneControl == 8'h18
        && !railsOkOutput && !sdaOe) else $error("reset values wrong");
    // protected register only moves inside a byte, while scl is low
    a_buck_in_byte: assert property ($changed(buckOneControl) |-> !sclIn)
        else $error("buck one control changed outside a write byte");
    // open-drain data pin never drives high
    a_sda_open_drain: assert property (sdaOe |-> !sdaOut)
        else $error("data pin driven high");
    a_sda_low_phase: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data pin changed while scl high");
    a_ack_holds: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("acknowledge or data bit too short");
    // a buck flag low for long enough forces the output low
    a_ok_falls: assert property ((!(&railGood[4:2])) [*6] |-> !railsOkOutput)
        else $error("output high with a buck rail not good");
    a_ok_holds: assert property ((&railGood) [*6] ##0 $past(railsOkOutput)
        |-> railsOkOutput) else $error("output dropped with all rails good");
    a_ok_rise_delay: assert property ($rose(railsOkOutput) |->
        $past(&railGood[4:2], 5) && $past(&railGood[4:2], 20))
        else $error("output rose before the delay");

    c_ok_rise: cover property ($rose(railsOkOutput));
    c_buck_write: cover property ($changed(buckOneControl));
    c_dev_ack: cover property ($rose(sdaOe));
endmodule

bind pgwl_power_good_lock pgwl_checker #(.BUS_ADDR(BUS_ADDR), .DLY0_CYC(DLY0_CYC),
    .DLY1_CYC(DLY1_CYC), .DLY2_CYC(DLY2_CYC), .DLY3_CYC(DLY3_CYC)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .railGood(railGood), .loadSwitchA(loadSwitchA),
    .loadSwitchB(loadSwitchB), .railsOkOutput(railsOkOutput),
    .buckOneControl(buckOneControl));

//--- sim/pgwl_i2c_host.sv
// pgwl_i2c_host: behavioural two-wire host driving scl and sharing sda with the device.
// assumes pull-ups on both lines; the device pulls sda low while sdaOe is high.
`timescale 1ns/1ps
module pgwl_i2c_host (
    input  wire logic core_clk,
    input  wire logic sdaOe,
    output logic      scl,
    output logic      sda
);
    logic hostLow = 1'b0;
    // wired-and of both pull-downs over the pull-up
    assign sda = !(hostLow || sdaOe);
    initial scl = 1'b1;

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        hostLow <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(8);
        hostLow <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask
    // stop: sda rises while scl high, then both lines stay released
    task automatic stop();
        hostLow <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        hostLow <= 1'b0;
        tick(8);
    endtask
    // one bit: set data in scl low, sample at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        hostLow <= !b;
        tick(4);
        scl <= 1'b1;
        tick(8);
        r = sda;
        scl <= 1'b0;
        tick(4);
    endtask
    // byte msb first, ninth bit sent as given and read back
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic nine);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(last, nine);
    endtask
endmodule

//--- sim/power_good_and_write_lock_test.sv
// power_good_and_write_lock_test: self-checking bench for the register bank and output.
// assumes the host model on the bus and shortened delay counts.
`timescale 1ns/1ps
module power_good_and_write_lock_test;
    import pgwl_pkg::*;
    localparam int         DLY [4]    = '{20, 100, 200, 400};
    localparam logic [7:0] BADKEY [4] = '{8'h00, 8'h7c, 8'h7e, 8'hff};
    localparam logic [7:0] AW         = {PGWL_BUS_ADDR, 1'b0};
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sclIn, sdaIn, sdaOut, sdaOe, railsOkOutput;
    logic        loadSwitchA = 1'b0;
    logic        loadSwitchB = 1'b0;
    pgwl_rails_s railGood = '0;
    logic [7:0]  buckOneControl, seenVal;
    logic [7:0]  expQ [$];
    int          n_fail = 0;
    int          total_checks = 0;
    event        seenEv;

    always #2.5 core_clk = ~core_clk;

    pgwl_i2c_host host (.core_clk(core_clk), .sdaOe(sdaOe), .scl(sclIn), .sda(sdaIn));
    pgwl_power_good_lock #(.DLY0_CYC(PGWL_DLY_W'(DLY[0])), .DLY1_CYC(PGWL_DLY_W'(DLY[1])),
        .DLY2_CYC(PGWL_DLY_W'(DLY[2])), .DLY3_CYC(PGWL_DLY_W'(DLY[3]))) uut (
        .core_clk(core_clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .railGood(railGood), .loadSwitchA(loadSwitchA),
        .loadSwitchB(loadSwitchB), .railsOkOutput(railsOkOutput),
        .buckOneControl(buckOneControl));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [7:0] e);
        expQ.push_back(e);
    endtask
    task automatic emit(input logic [7:0] v);
        seenVal = v;
        ->seenEv;
        @(negedge core_clk);
    endtask
    // watcher: every seen result is paired with the oldest note
    always @(seenEv) begin
        check(seenVal, expQ.pop_front());
    end

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] q;
        logic       n;
        host.start();
        host.xfer(AW, 1'b1, q, n);
        host.xfer(ptr, 1'b1, q, n);
        host.xfer(d, 1'b1, q, n);
        host.stop();
    endtask
    // pointer write, repeated start, then cnt bytes with a final nack
    task automatic rd(input logic [7:0] ptr, input int cnt);
        logic [7:0] q;
        logic       n;
        host.start();
        host.xfer(AW, 1'b1, q, n);
        host.xfer(ptr, 1'b1, q, n);
        host.start();
        host.xfer(AW | 8'h01, 1'b1, q, n);
        for (int i = 0; i < cnt; i++) begin
            host.xfer(8'hff, i == cnt - 1, q, n);
            emit(q);
        end
        host.stop();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog against a hung bus or output
    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end

    // main sequence
    initial begin
        logic [7:0] q;
        logic       n;
        int         cnt;
        void'($urandom(38));
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        // reset values, auto-increment and one unmapped offset
        foreach (BADKEY[i]) note(8'h00);
        expQ[2] = 8'h0c;
        expQ[3] = 8'h18;
        note(8'h00);
        rd(PGWL_OFS_KEY, 5);
        // a foreign address gets no acknowledge
        host.start();
        host.xfer(AW ^ 8'h02, 1'b1, q, n);
        host.stop();
        note(8'h01);
        emit({7'h0, n});
        // status follows random rail flags and switches
        repeat (4) begin
            @(posedge core_clk);
            railGood <= pgwl_rails_s'(7'($urandom));
            {loadSwitchA, loadSwitchB} <= 2'($urandom);
            repeat (2) @(posedge core_clk);
            note({1'b0, railGood.linearCGood | loadSwitchA,
                  railGood.linearDGood | loadSwitchB, railGood[4:0]});
            rd(PGWL_OFS_STATUS, 1);
        end
        // each of four other key values (00, 7c, 7e, ff) keeps the config locked
        foreach (BADKEY[i]) begin
            wr(PGWL_OFS_KEY, BADKEY[i]);
            wr(PGWL_OFS_CFG, 8'h03);
            note(8'h0c);
            rd(PGWL_OFS_CFG, 1);
        end
        // key opens exactly one write, reserved bits dropped
        wr(PGWL_OFS_KEY, PGWL_UNLOCK_KEY);
        wr(PGWL_OFS_CFG, 8'hf3);
        wr(PGWL_OFS_CFG, 8'h0c);
        note(8'h00);
        note(8'h00);
        expQ[$] = {1'b0, railGood.linearCGood | loadSwitchA,
                   railGood.linearDGood | loadSwitchB, railGood[4:0]};
        note(8'h03);
        rd(PGWL_OFS_KEY, 3);
        // a read transaction consumes the key
        wr(PGWL_OFS_KEY, PGWL_UNLOCK_KEY);
        note(8'h00);
        rd(PGWL_OFS_KEY, 1);
        wr(PGWL_OFS_BUCK1, 8'ha5);
        note(8'h18);
        emit(buckOneControl);
        wr(PGWL_OFS_KEY, PGWL_UNLOCK_KEY);
        wr(PGWL_OFS_BUCK1, 8'ha5);
        note(8'ha5);
        emit(buckOneControl);
        // each delay with one linear masked, the other counted
        for (int s = 0; s < 4; s++) begin
            railGood <= '0;
            wr(PGWL_OFS_KEY, PGWL_UNLOCK_KEY);
            wr(PGWL_OFS_CFG, {4'h0, s[0] ? 2'b01 : 2'b10, 2'(s)});
            railGood <= 7'h7c;
            repeat (DLY[s] + 20) @(posedge core_clk);
            note(8'h00);
            emit({7'h0, railsOkOutput});
            railGood <= s[0] ? 7'h7e : 7'h7d;
            cnt = 0;
            while (railsOkOutput !== 1'b1 && cnt < DLY[s] + 50) begin
                @(negedge core_clk);
                cnt++;
            end
            note(8'h01);
            emit({7'h0, cnt >= DLY[s] && cnt <= DLY[s] + 10});
            railGood <= 7'h6d;
            repeat (7) @(posedge core_clk);
            note(8'h00);
            emit({7'h0, railsOkOutput});
        end
        wrap_up();
    end
endmodule
